// ==== rtl/indicator_priority_display.sv ====
// indicator latching, fault code, display arbitration and setting banks
// assumes synchronous inputs, one clock and a strobe register port
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "earth_fault_params.svh"
module indicator_priority_display #(
  parameter int FLASH_CYCLES = (`FLASH_HALF_MS * 1000000) / `CLK_PERIOD_NS
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire earth_fault_pkg::stage_events_t events_in,
  input wire logic trip_link_in,
  input wire logic button_reset_in,
  input wire logic ext_reset_in,
  input wire logic output_latch_held_in,
  input wire logic fault_detect_in,
  input wire logic [3:0] fault_type_in,
  output logic [7:0] principle_select_out,
  output earth_fault_pkg::setting_bank_t active_settings_out,
  output logic second_bank_active_out,
  output logic trip_lamp_out,
  output logic internal_fault_lamp_out,
  output logic supervision_relay_out,
  output earth_fault_pkg::display_t display_out,
  output logic [5:0] setting_lamps_out
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // priority level index of an event, 0 is breaker failure
  function automatic logic [2:0] evt_level(input logic [4:0] i);
    if (i == 5'h00)
      evt_level = 3'h0;
    else if (i < 5'h08)
      evt_level = 3'h1;
    else if (i < 5'h0a)
      evt_level = 3'h2;
    else if (i < 5'h0f)
      evt_level = 3'h3;
    else if (i < 5'h14)
      evt_level = 3'h4;
    else
      evt_level = 3'h5;
  endfunction : evt_level

  // code of one external control signal
  function automatic logic [3:0] ext_code(input logic [2:0] k);
    case (k)
      3'h0: ext_code = 4'h7;
      3'h1: ext_code = 4'h8;
      3'h2: ext_code = 4'h9;
      3'h3: ext_code = 4'h0;
      default: ext_code = 4'hb;
    endcase
  endfunction : ext_code

  // red operation code of an event
  // operation code table
  function automatic logic [3:0] evt_code(input logic [4:0] i);
    case (i)
      5'h00: evt_code = 4'ha;
      5'h01: evt_code = 4'h2;
      5'h02: evt_code = 4'h5;
      5'h08: evt_code = 4'h1;
      5'h09: evt_code = 4'h4;
      5'h14: evt_code = 4'h3;
      5'h15: evt_code = 4'h6;
      default:
      begin
        if (i < 5'h08)
          evt_code = ext_code(3'(i - 5'h03));
        else if (i < 5'h0f)
          evt_code = ext_code(3'(i - 5'h0a));
        else
          evt_code = ext_code(3'(i - 5'h0f));
      end
    endcase
  endfunction : evt_code

  // range and default per setting index, pairs are hv then lv
  function automatic logic [13:0] set_min(input logic [3:0] idx);
    case (idx[3:1])
      3'h0: set_min = `START_MIN;
      3'h1: set_min = `DELAY_MIN;
      3'h3: set_min = `RATIO_MIN;
      3'h4: set_min = `HARM_MIN;
      default: set_min = `CT_MIN;
    endcase
  endfunction : set_min

  function automatic logic [13:0] set_max(input logic [3:0] idx);
    case (idx[3:1])
      3'h0: set_max = `START_MAX;
      3'h1: set_max = `DELAY_MAX;
      3'h3: set_max = `RATIO_MAX;
      3'h4: set_max = `HARM_MAX;
      default: set_max = `CT_MAX;
    endcase
  endfunction : set_max

  function automatic logic [13:0] set_default(input logic [3:0] idx);
    case (idx[3:1])
      3'h0: set_default = `START_DEF;
      3'h1: set_default = `DELAY_DEF;
      3'h3: set_default = `RATIO_DEF;
      3'h4: set_default = `HARM_DEF;
      default: set_default = `CT_DEF;
    endcase
  endfunction : set_default

  // clamp into range; delays from 10 s take 0.1 s steps only
  // coarse delay steps
  function automatic logic [13:0] clamp_setting(input logic [3:0] idx,
    input logic [13:0] v);
    logic [13:0] c;
    c = v;
    if (c < set_min(idx))
      c = set_min(idx);
    if (c > set_max(idx))
      c = set_max(idx);
    if (idx[3:1] == 3'h1 && c >= `DELAY_COARSE)
      c = c - (c % `DELAY_STEP);
    clamp_setting = c;
  endfunction : clamp_setting

  // three decimal digits; large values drop low digits to fit
  function automatic logic [11:0] to_bcd3(input logic [13:0] v);
    logic [13:0] d;
    d = v;
    if (d >= 14'h2710)
      d = d / 14'h0064;
    else if (d >= 14'h03e8)
      d = d / 14'h000a;
    to_bcd3 = {4'(d / 14'h0064), 4'((d / 14'h000a) % 14'h000a),
      4'(d % 14'h000a)};
  endfunction : to_bcd3

  // ****************************************************************
  // state
  // ****************************************************************

  earth_fault_pkg::state_t state;
  earth_fault_pkg::state_t next_state;
  logic [21:0] pending;
  logic any_reset;
  logic bus_reset;
  logic [2:0] best_lvl;
  logic [4:0] chosen;
  logic found;
  logic [3:0] sidx;
  logic [13:0] sval;

  // ****************************************************************
  // next state
  // ****************************************************************

  always_comb
  begin
    next_state = state;
    bus_reset = 1'b0;
    pending = '0;
    best_lvl = 3'h7;
    chosen = 5'h00;
    found = 1'b0;
    sidx = addr_in[5:2];
    sval = 14'h0000;
    // bus writes; second bank ranges match the main bank
    if (wr_in)
    begin
      case (addr_in)
        `ADDR_PRINCIPLE:
          next_state.principle = wdata_in[7:0];
        `ADDR_COMMAND:
        begin
          if (wdata_in[7:4] == `CMD_SUB_RESET)
            bus_reset = wdata_in[0];
          if (wdata_in[7:4] == `CMD_SUB_BANK)
            next_state.second_active = wdata_in[0];
        end
        `ADDR_DISPLAY:
        begin
          next_state.disp_mode = earth_fault_pkg::disp_mode_t'(wdata_in[1:0]);
          next_state.disp_index = wdata_in[7:4];
        end
        default:
        begin
          if (sidx < 4'hc && addr_in[1:0] == 2'h0)
          begin
            if (addr_in[7:6] == `BANK_MAIN)
              next_state.bank[0][sidx] = clamp_setting(sidx, wdata_in[13:0]);
            if (addr_in[7:6] == `BANK_SECOND)
              next_state.bank[1][sidx] = clamp_setting(sidx, wdata_in[13:0]);
          end
        end
      endcase
    end
    // read data stand one cycle only, unmapped reads give zero
    next_state.rdata = 32'h0000_0000;
    if (rd_in)
    begin
      case (addr_in)
        `ADDR_PRINCIPLE: next_state.rdata = {24'h00_0000, state.principle};
        `ADDR_STATUS: next_state.rdata = {13'h0000, state.fault_code,
          state.fault, state.second_active, state.trip_lamp, state.ext_op,
          state.latch_flags};
        `ADDR_DISPLAY: next_state.rdata = {24'h00_0000, state.disp_index,
          2'h0, state.disp_mode};
        default:
        begin
          if (sidx < 4'hc && addr_in[1:0] == 2'h0)
          begin
            if (addr_in[7:6] == `BANK_MAIN)
              next_state.rdata = {18'h0_0000, state.bank[0][sidx]};
            if (addr_in[7:6] == `BANK_SECOND)
              next_state.rdata = {18'h0_0000, state.bank[1][sidx]};
          end
        end
      endcase
    end
    // a held output latch blocks the reset
    any_reset = (button_reset_in | ext_reset_in | bus_reset) &
      ~output_latch_held_in;
    // set wins over reset; flags: cbfp, hv op, lv op, hv st, lv st
    // latch until reset
    next_state.latch_flags[0] = events_in.cbfp_operate |
      (state.latch_flags[0] & ~any_reset);
    next_state.latch_flags[1] = events_in.hv_operate |
      (state.latch_flags[1] & ~any_reset);
    next_state.latch_flags[2] = events_in.lv_operate |
      (state.latch_flags[2] & ~any_reset);
    next_state.latch_flags[3] = events_in.hv_start |
      (state.latch_flags[3] & ~any_reset);
    next_state.latch_flags[4] = events_in.lv_start |
      (state.latch_flags[4] & ~any_reset);
    next_state.latch_flags[6:5] = 2'h0;
    next_state.ext_op = events_in.ext_operate | (state.ext_op & ~{5{any_reset}});
    next_state.trip_lamp = ((events_in.hv_operate | events_in.lv_operate |
      (|events_in.ext_operate)) & trip_link_in) |
      (state.trip_lamp & ~any_reset);
    // permanent fault latches once; only power-up reset clears it
    // fault code capture
    if (fault_detect_in && !state.fault)
    begin
      next_state.fault = 1'b1;
      next_state.fault_code = fault_type_in;
    end
    // pending events in index order; blocking and activation are live
    pending[0] = state.latch_flags[0];
    pending[1] = state.latch_flags[1];
    pending[2] = state.latch_flags[2];
    pending[7:3] = state.ext_op;
    pending[8] = state.latch_flags[3];
    pending[9] = state.latch_flags[4];
    pending[14:10] = events_in.ext_active & events_in.ext_latching;
    pending[19:15] = events_in.ext_active & ~events_in.ext_latching;
    pending[20] = events_in.hv_block;
    pending[21] = events_in.lv_block;
    // newest rising event per level; descending so low index wins ties
    // most recent event
    for (int i = 21; i >= 0; i--)
    begin
      if (pending[i] && !state.prev_pending[i])
        next_state.last_evt[evt_level(5'(i))] = 5'(i);
    end
    next_state.prev_pending = pending;
    for (int i = 0; i < 22; i++)
    begin
      if (pending[i] && evt_level(5'(i)) < best_lvl)
        best_lvl = evt_level(5'(i));
    end
    if (best_lvl != 3'h7)
    begin
      if (pending[state.last_evt[best_lvl]] &&
          evt_level(state.last_evt[best_lvl]) == best_lvl)
      begin
        chosen = state.last_evt[best_lvl];
        found = 1'b1;
      end
      for (int i = 21; i >= 0; i--)
      begin
        if (!found && pending[i] && evt_level(5'(i)) == best_lvl)
          chosen = 5'(i);
      end
    end
    // flash timebase runs always so the lamps keep a steady rhythm
    if (state.flash_cnt >= 32'(FLASH_CYCLES - 1))
    begin
      next_state.flash_cnt = 32'h0000_0000;
      next_state.flash_on = ~state.flash_on;
    end
    else
      next_state.flash_cnt = state.flash_cnt + 32'h0000_0001;
    // display and lamps
    next_state.lamps = 6'h00;
    next_state.display.red = `CODE_BLANK;
    next_state.display.green = {3{`CODE_BLANK}};
    case (state.disp_mode)
      earth_fault_pkg::DISP_SETTING:
      begin
        if (state.disp_index < 4'hc)
        begin
          sval = state.bank[state.second_active][state.disp_index];
          next_state.display.green = to_bcd3(sval);
          // red digit picks hv or lv
          next_state.display.red = {3'h0, state.disp_index[0]} + 4'h1;
          if (!state.second_active || state.flash_on)
            next_state.lamps = 6'h01 << state.disp_index[3:1];
        end
      end
      earth_fault_pkg::DISP_SWITCH_EDIT:
      begin
        if (state.disp_index >= 4'h1 && state.disp_index <= 4'h8)
          next_state.display.green = {`CODE_BLANK, state.disp_index,
            3'h0, state.principle[3'(state.disp_index - 4'h1)]};
      end
      earth_fault_pkg::DISP_CHECKSUM:
        next_state.display.green = to_bcd3({6'h00, state.principle});
      default:
      begin
        if (best_lvl != 3'h7)
          next_state.display.red = evt_code(chosen);
      end
    endcase
    // fault code overrides every other display content
    // fault code on top
    if (state.fault)
    begin
      next_state.display.red = `CODE_FAULT_RED;
      next_state.display.green = {`CODE_BLANK, `CODE_BLANK, state.fault_code};
    end
    // registered copy keeps stage settings glitch-free on bank switch
    next_state.active = state.bank[state.second_active];
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // reset loads defaults; clock enable freezes everything
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= '0;
      state.principle <= `PRINCIPLE_RESET;
      state.display <= {`CODE_BLANK, {3{`CODE_BLANK}}};
      for (int i = 0; i < 12; i++)
      begin
        state.bank[0][i] <= set_default(4'(i));
        state.bank[1][i] <= set_default(4'(i));
        state.active[i] <= set_default(4'(i));
      end
    end
    else if (ce_in)
      state <= next_state;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // indicator state is only exported, never fed to stage logic
  // indicators isolated
  assign principle_select_out = state.principle;
  assign active_settings_out = state.active;
  assign second_bank_active_out = state.second_active;
  assign trip_lamp_out = state.trip_lamp;
  assign internal_fault_lamp_out = state.fault;
  assign supervision_relay_out = state.fault;
  assign display_out = state.display;
  assign setting_lamps_out = state.lamps;
  assign rdata_out = state.rdata;

endmodule : indicator_priority_display

// ==== rtl/earth_fault_params.svh ====
// offsets, field positions, reset values and timing counts of the
// indicator and display block; assumes a 40 MHz module clock.
`ifndef EARTH_FAULT_PARAMS_SVH
`define EARTH_FAULT_PARAMS_SVH
`define ADDR_PRINCIPLE 8'h00
`define ADDR_COMMAND 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_DISPLAY 8'h0c
`define BANK_MAIN 2'h1
`define BANK_SECOND 2'h2
`define CMD_SUB_RESET 4'h1
`define CMD_SUB_BANK 4'h4
`define PRINCIPLE_RESET 8'h00
`define START_MIN 14'h0005
`define START_MAX 14'h0032
`define START_DEF 14'h0005
`define DELAY_MIN 14'h0003
`define DELAY_MAX 14'h2710
`define DELAY_DEF 14'h0003
`define DELAY_COARSE 14'h03e8
`define DELAY_STEP 14'h000a
`define CT_MIN 14'h0028
`define CT_MAX 14'h0096
`define CT_DEF 14'h0064
`define RATIO_MIN 14'h0000
`define RATIO_MAX 14'h0014
`define RATIO_DEF 14'h000a
`define HARM_MIN 14'h000a
`define HARM_MAX 14'h0032
`define HARM_DEF 14'h001e
`define CODE_BLANK 4'hf
`define CODE_FAULT_RED 4'h1
`define CLK_PERIOD_NS 25
`define FLASH_HALF_MS 500
`endif

// ==== rtl/earth_fault_pkg.sv ====
// types shared by the indicator and display block
// assumes the constants header is included by each user
package earth_fault_pkg;
  typedef enum logic [1:0] {DISP_EVENTS, DISP_SETTING, DISP_SWITCH_EDIT,
    DISP_CHECKSUM} disp_mode_t;
  typedef logic [13:0] setting_t;
  typedef setting_t [11:0] setting_bank_t;
  typedef struct packed {
    logic hv_start;
    logic hv_operate;
    logic lv_start;
    logic lv_operate;
    logic hv_block;
    logic lv_block;
    logic cbfp_operate;
    logic [4:0] ext_active;
    logic [4:0] ext_operate;
    logic [4:0] ext_latching;
  } stage_events_t;
  typedef struct packed {
    logic [3:0] red;
    logic [11:0] green;
  } display_t;
  typedef struct packed {
    logic [7:0] principle;
    setting_bank_t [1:0] bank;
    logic second_active;
    setting_bank_t active;
    logic [6:0] latch_flags;
    logic [4:0] ext_op;
    logic trip_lamp;
    logic fault;
    logic [3:0] fault_code;
    logic [21:0] prev_pending;
    logic [5:0][4:0] last_evt;
    disp_mode_t disp_mode;
    logic [3:0] disp_index;
    logic [31:0] flash_cnt;
    logic flash_on;
    display_t display;
    logic [5:0] lamps;
    logic [31:0] rdata;
  } state_t;
endpackage : earth_fault_pkg

// ==== verif/ipd_monitor.sv ====
// concurrent checks on the ports of the indicator and display block
// assumes one clock domain and the constants header on the include path
`timescale 1ns/100ps
`include "earth_fault_params.svh"
module ipd_monitor #(
  parameter int FLASH_CYCLES = 4
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire earth_fault_pkg::stage_events_t events_in,
  input wire logic trip_link_in,
  input wire logic button_reset_in,
  input wire logic ext_reset_in,
  input wire logic output_latch_held_in,
  input wire logic fault_detect_in,
  input wire logic [3:0] fault_type_in,
  input wire logic [7:0] principle_select_out,
  input wire logic second_bank_active_out,
  input wire logic trip_lamp_out,
  input wire logic internal_fault_lamp_out,
  input wire logic supervision_relay_out,
  input wire earth_fault_pkg::display_t display_out
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic op_now;
  logic quiet;
  // any stage operate, and no source that could set the lamp again
  assign op_now = events_in.hv_operate | events_in.lv_operate;
  assign quiet = !op_now && events_in.ext_operate == 5'h0
    && !events_in.cbfp_operate;
  sequence fault_seen;
    ce_in && fault_detect_in && !internal_fault_lamp_out;
  endsequence
  sequence fault_shown;
    display_out.red == `CODE_FAULT_RED
      && display_out.green[3:0] == $past(fault_type_in, 2);
  endsequence
  fault_lamp_a: assert property (ce_in && fault_detect_in |=>
    internal_fault_lamp_out) else $error("fault lamp not lit");
  relay_match_a: assert property (supervision_relay_out ==
    internal_fault_lamp_out) else $error("relay differs from lamp");
  fault_sticky_a: assert property (internal_fault_lamp_out |=>
    internal_fault_lamp_out) else $error("fault lamp cleared");
  fault_code_a: assert property (fault_seen ##1 ce_in |=>
    fault_shown) else $error("fault code not shown");
  trip_set_a: assert property (ce_in && trip_link_in && op_now |=>
    trip_lamp_out) else $error("trip lamp not lit");
  trip_hold_a: assert property (trip_lamp_out && !button_reset_in
    && !ext_reset_in && !wr_in |=> trip_lamp_out)
    else $error("trip lamp dropped without reset");
  latch_hold_a: assert property (trip_lamp_out &&
    output_latch_held_in |=> trip_lamp_out) else $error("held lamp lost");
  reset_clear_a: assert property (trip_lamp_out && ce_in && quiet
    && (button_reset_in || ext_reset_in) && !output_latch_held_in
    |=> !trip_lamp_out) else $error("reset did not clear trip lamp");
  principle_wr_a: assert property (ce_in && wr_in && addr_in ==
    `ADDR_PRINCIPLE |=> principle_select_out == $past(wdata_in[7:0]))
    else $error("principle bank not written");
  bank_sel_a: assert property (ce_in && wr_in && addr_in ==
    `ADDR_COMMAND && wdata_in[7:4] == `CMD_SUB_BANK
    |=> second_bank_active_out == $past(wdata_in[0]))
    else $error("bank select not taken");
endmodule : ipd_monitor
bind indicator_priority_display ipd_monitor #(
  .FLASH_CYCLES(FLASH_CYCLES)) i_mon (.core_clk_in(core_clk_in),
  .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .events_in(events_in),
  .trip_link_in(trip_link_in), .button_reset_in(button_reset_in),
  .ext_reset_in(ext_reset_in), .output_latch_held_in(output_latch_held_in),
  .fault_detect_in(fault_detect_in), .fault_type_in(fault_type_in),
  .principle_select_out(principle_select_out),
  .second_bank_active_out(second_bank_active_out),
  .trip_lamp_out(trip_lamp_out),
  .internal_fault_lamp_out(internal_fault_lamp_out),
  .supervision_relay_out(supervision_relay_out),
  .display_out(display_out));

// ==== verif/panel_buttons.sv ====
// front panel push-button model driving the indicator reset request
// assumes the bench pulses press_in for one clock per press
`timescale 1ns/100ps
module panel_buttons #(
  parameter int HOLD_CYCLES = 3
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic press_in,
  output logic button_reset_out
);
  int left;
  // a human press spans several clocks; the block must treat it as one
  // panel reset source
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      left <= 0;
      button_reset_out <= 1'b0;
    end
    else
    begin
      left <= press_in ? HOLD_CYCLES : (left > 0 ? left - 1 : 0);
      button_reset_out <= press_in || left > 1;
    end
  end
endmodule : panel_buttons

// ==== verif/test_indicator_priority_display.sv ====
// self-checking bench for the indicator and display block
// assumes the panel model and the bound monitor compile beside it
`timescale 1ns/100ps
`include "earth_fault_params.svh"
module test_indicator_priority_display;
  localparam int LO[6] = '{`START_MIN, `DELAY_MIN, `CT_MIN, `RATIO_MIN,
    `HARM_MIN, `CT_MIN};
  localparam int HI[6] = '{`START_MAX, `DELAY_MAX, `CT_MAX, `RATIO_MAX,
    `HARM_MAX, `CT_MAX};
  localparam int DEF[6] = '{`START_DEF, `DELAY_DEF, `CT_DEF, `RATIO_DEF,
    `HARM_DEF, `CT_DEF};
  // event bit in the packed struct, status bit and display code
  localparam int EBIT[6] = '{21, 20, 19, 18, 15, 5};
  localparam int SBIT[6] = '{3, 1, 4, 2, 0, 7};
  localparam int CODE[6] = '{1, 2, 4, 5, 10, 7};
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  earth_fault_pkg::stage_events_t ev = '0;
  earth_fault_pkg::stage_events_t e;
  logic trip_link = 1'b0;
  logic press = 1'b0;
  logic button;
  logic ext_reset = 1'b0;
  logic held = 1'b0;
  logic fdet = 1'b0;
  logic [3:0] ftype = 4'h0;
  logic [7:0] psel;
  earth_fault_pkg::setting_bank_t act;
  logic second;
  logic trip;
  logic ifl;
  logic relay;
  earth_fault_pkg::display_t disp;
  logic [5:0] lamps;
  logic [31:0] lfsr = 32'h2c554a55;
  logic [31:0] d;
  logic [31:0] q;
  int m_bank[12];
  int fails = 0;
  int checks_done = 0;
  int on_n;
  int off_n;

  always #12.5 core_clk_in = ~core_clk_in;

  panel_buttons i_panel (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .press_in(press), .button_reset_out(button));
  indicator_priority_display #(.FLASH_CYCLES(4)) i_dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .events_in(ev), .trip_link_in(trip_link),
    .button_reset_in(button), .ext_reset_in(ext_reset),
    .output_latch_held_in(held), .fault_detect_in(fdet),
    .fault_type_in(ftype), .principle_select_out(psel),
    .active_settings_out(act), .second_bank_active_out(second),
    .trip_lamp_out(trip), .internal_fault_lamp_out(ifl),
    .supervision_relay_out(relay), .display_out(disp),
    .setting_lamps_out(lamps));

  // ****************************************
  // model, bus master and compare tasks
  // ****************************************
  function automatic int clampv(input int i, input int v);
    int r;
    r = v < LO[i >> 1] ? LO[i >> 1] : (v > HI[i >> 1] ? HI[i >> 1] : v);
    // long delays only keep the coarse step
    if ((i >> 1) == 1 && r >= 1000)
      r = r - r % 10;
    return r;
  endfunction : clampv
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : settle
  task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask : bus_write
  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : bus_read
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_flag
  task automatic fire(input earth_fault_pkg::stage_events_t x, input logic l);
    @(posedge core_clk_in);
    ev <= x;
    trip_link <= l;
    @(posedge core_clk_in);
    ev <= '0;
    trip_link <= 1'b0;
  endtask : fire
  // source 0 panel, 1 external input, 2 bus command
  task automatic do_reset(input int src);
    if (src == 2)
      bus_write(`ADDR_COMMAND, {24'h0, `CMD_SUB_RESET, 4'h1});
    else
    begin
      @(posedge core_clk_in);
      press <= src == 0;
      ext_reset <= src == 1;
      @(posedge core_clk_in);
      press <= 1'b0;
      ext_reset <= 1'b0;
    end
    settle(5);
  endtask : do_reset
  task automatic one_event(input int k);
    e = '0;
    e[EBIT[k]] = 1'b1;
  endtask : one_event
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    settle(1);
    cmp_word({16'h0, disp}, 32'hffff);
    cmp_word({24'h0, psel}, `PRINCIPLE_RESET);
    for (int i = 0; i < 12; i++)
    begin
      m_bank[i] = DEF[i >> 1];
      cmp_word({18'h0, act[i]}, m_bank[i]);
    end
    // principle bank, unmapped and read-only places
    for (int i = 0; i < 3; i++)
    begin
      d = rnd() & 32'hff;
      bus_write(`ADDR_PRINCIPLE, d);
      bus_read(`ADDR_PRINCIPLE, q);
      cmp_word(q, d);
      cmp_word({24'h0, psel}, d);
    end
    bus_write(`ADDR_STATUS, 32'hffffffff);
    bus_read(`ADDR_STATUS, d);
    cmp_word(d, 32'h0);
    bus_read(8'h3c, d);
    cmp_word(d, 32'h0);
    // random settings clamped to range and step
    for (int i = 0; i < 13; i++)
    begin
      d = (i == 12) ? 32'd1234 : rnd() & 32'h3fff;
      m_bank[i == 12 ? 2 : i] = clampv(i == 12 ? 2 : i, d);
      bus_write(8'h40 + 8'(4 * (i == 12 ? 2 : i)), d);
      bus_read(8'h40 + 8'(4 * (i == 12 ? 2 : i)), d);
      cmp_word(d, m_bank[i == 12 ? 2 : i]);
    end
    settle(2);
    for (int i = 0; i < 12; i++)
      cmp_word({18'h0, act[i]}, m_bank[i]);
    // six event codes, latched after the event drops
    for (int k = 0; k < 6; k++)
    begin
      one_event(k);
      fire(e, 1'b0);
      settle(3);
      cmp_word({28'h0, disp.red}, CODE[k]);
      bus_read(`ADDR_STATUS, d);
      cmp_word(d & 32'hfff, 1 << SBIT[k]);
      do_reset(k % 3);
      cmp_word({16'h0, disp}, 32'hffff);
    end
    // trip lamp, held output latch, then each reset source
    one_event(1);
    fire(e, 1'b1);
    held <= 1'b1;
    do_reset(0);
    cmp_flag(trip, 1'b1);
    held <= 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      fire(e, 1'b1);
      settle(2);
      bus_read(`ADDR_STATUS, d);
      cmp_word(d, 32'h1002);
      do_reset(s);
      cmp_flag(trip, 1'b0);
    end
    // priority over lower level, then latest within a level
    one_event(2);
    fire(e, 1'b0);
    one_event(1);
    fire(e, 1'b0);
    settle(3);
    cmp_word({28'h0, disp.red}, 32'h2);
    do_reset(1);
    one_event(0);
    fire(e, 1'b0);
    one_event(2);
    fire(e, 1'b0);
    settle(3);
    cmp_word({28'h0, disp.red}, 32'h4);
    do_reset(2);
    // second bank, flashing lamps, switch edit and checksum
    bus_write(`ADDR_COMMAND, {24'h0, `CMD_SUB_BANK, 4'h1});
    bus_write(8'h80, 32'h20);
    bus_write(`ADDR_DISPLAY, 32'h01);
    settle(2);
    cmp_flag(second, 1'b1);
    cmp_word({18'h0, act[0]}, 32'h20);
    cmp_word({16'h0, disp}, 32'h1032);
    for (int p = 0; p < 2; p++)
    begin
      on_n = 0;
      off_n = 0;
      repeat (12)
      begin
        settle(1);
        if (lamps !== 6'h0)
          on_n++;
        else
          off_n++;
      end
      cmp_flag(off_n > 0, p == 0);
      cmp_flag(on_n > 0, 1'b1);
      bus_write(`ADDR_COMMAND, {24'h0, `CMD_SUB_BANK, 4'h0});
    end
    settle(2);
    cmp_word({18'h0, act[0]}, m_bank[0]);
    bus_write(`ADDR_PRINCIPLE, 32'h04);
    bus_write(`ADDR_DISPLAY, 32'h32);
    settle(3);
    cmp_word({20'h0, disp.green}, 32'hf31);
    bus_write(`ADDR_DISPLAY, 32'h03);
    settle(3);
    cmp_word({20'h0, disp.green}, 32'h004);
    bus_write(`ADDR_DISPLAY, 32'h00);
    // internal fault survives the bus and panel indicator resets
    @(posedge core_clk_in);
    ftype <= 4'(rnd());
    fdet <= 1'b1;
    settle(3);
    fdet <= 1'b0;
    cmp_flag(ifl, 1'b1);
    cmp_flag(relay, 1'b1);
    bus_read(`ADDR_STATUS, d);
    cmp_word(d & 32'h7c000, {ftype, 15'h4000});
    one_event(1);
    fire(e, 1'b1);
    do_reset(2);
    do_reset(0);
    cmp_flag(ifl, 1'b1);
    cmp_word({28'h0, disp.red}, `CODE_FAULT_RED);
    // second reset in mid-run clears the fault lamp and blanks the display
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    settle(2);
    rstn_in <= 1'b1;
    settle(1);
    cmp_flag(ifl, 1'b0);
    cmp_word({16'h0, disp}, 32'hffff);
    report_and_stop();
  end
endmodule : test_indicator_priority_display
